// *** src/ttu_table_unit.sv ***
// Table transfer unit: moves single bytes between program memory space
// and the core through a byte pointer and a byte latch.
// Assumes memory answers with the addressed word within the access time
// and that the programming mode pin is asynchronous to the core clock.
// Ops may follow back to back; the register port never waits.
//
// Our own choices: the register offsets and the strobed register port.
module ttu_table_unit (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Software register port.
    input wire logic [ttu_pkg::REG_AW-1:0] reg_addr_i,
    input wire logic [ttu_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [ttu_pkg::DATA_W-1:0] reg_rdata_o,
    // Table operation request from the core.
    input wire logic op_valid_i,
    input wire logic op_write_i,
    input wire ttu_pkg::ttu_ptr_mode_type op_mode_i,
    output logic op_ready_o,
    output logic op_done_o,
    // Program memory and external bus.
    output logic [ttu_pkg::PTR_W-1:0] mem_addr_o,
    output logic mem_cfg_sel_o,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic [ttu_pkg::DATA_W-1:0] mem_wdata_o,
    input wire logic [ttu_pkg::WORD_W-1:0] mem_rdata_i,
    // In-circuit programming of the internal array.
    input wire logic prog_mode_i,
    output logic row_prog_o,
    output logic [ttu_pkg::PTR_W-1:0] row_addr_o,
    output logic [ttu_pkg::BLK_BYTES*ttu_pkg::DATA_W-1:0] row_data_o
);
    import ttu_pkg::*;

    // Sequencer states, one-hot.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACCESS = 2'b10
    } ttu_state_type;

    // Control and register state.
    ttu_state_type state_q;
    ttu_state_type state_d;
    logic [PTR_W-1:0] ptr_q;
    logic [PTR_W-1:0] ptr_d;
    logic [PTR_W-1:0] after_q;
    logic [PTR_W-1:0] after_d;
    logic [DATA_W-1:0] latch_q;
    logic [DATA_W-1:0] latch_d;
    logic [WAIT_W-1:0] wait_q;
    logic [WAIT_W-1:0] wait_d;
    logic [WAIT_W+1:0] cnt_q;
    logic [WAIT_W+1:0] cnt_d;
    logic write_q;
    logic write_d;
    logic [PTR_W-1:0] addr_q;
    logic [PTR_W-1:0] addr_d;
    logic done_q;
    logic done_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic row_prog_q;
    logic row_prog_d;
    logic [PTR_W-1:0] row_addr_q;
    logic [PTR_W-1:0] row_addr_d;
    logic prog_meta_q;
    logic prog_sync_q;
    // Synchroniser next values.
    logic prog_meta_d;
    logic prog_sync_d;

    // Combinational helpers.
    logic [PTR_W-1:0] access_ptr;
    logic [PTR_W-1:0] after_ptr;
    logic accept;
    logic finish;
    logic blk_wr;
    logic [DATA_W-1:0] read_byte;

    // Pointer arithmetic for the requested update.
    // Both results settle before the take edge.
    ttu_ptr_update u_ptr_update (
        .ptr_i(ptr_q),
        .mode_i(op_mode_i),
        .access_ptr_o(access_ptr),
        .after_ptr_o(after_ptr)
    );

    // Block buffer for writes to the internal array.
    // Written only in programming mode.
    ttu_blk_buf #(
        .BYTES(BLK_BYTES),
        .OFS_W(BLK_OFS_W)
    ) u_blk_buf (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(blk_wr),
        .ofs_i(addr_q[BLK_OFS_W-1:0]),
        .byte_i(latch_q),
        .row_o(row_data_o)
    );

    // Brings the programming mode pin into the core clock domain.
    always_comb begin
        prog_meta_d = prog_mode_i;
        prog_sync_d = prog_meta_q;
    end

    // Registers the two synchroniser stages.
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prog_meta_q <= 1'b0;
            prog_sync_q <= 1'b0;
        end else begin
            prog_meta_q <= prog_meta_d;
            prog_sync_q <= prog_sync_d;
        end
    end

    // Handshake and access qualifiers.
    // Ready comes straight from the state register.
    assign op_ready_o = (state_q == ST_IDLE);
    assign accept = op_valid_i && op_ready_o;
    assign finish = (state_q == ST_ACCESS) && (cnt_q == '0);
    // Only programming mode may write the internal array.
    assign blk_wr = finish && write_q && prog_sync_q;

    // Picks one byte of the addressed word; odd addresses take the high one.
    // The word is settled by the last access cycle.
    assign read_byte = addr_q[0] ? mem_rdata_i[WORD_W-1:DATA_W]
                                 : mem_rdata_i[DATA_W-1:0];

    // Next state of the operation sequencer and the software registers.
    always_comb begin
        state_d = state_q;
        ptr_d = ptr_q;
        after_d = after_q;
        latch_d = latch_q;
        wait_d = wait_q;
        cnt_d = cnt_q;
        write_d = write_q;
        addr_d = addr_q;
        done_d = 1'b0;
        row_prog_d = 1'b0;
        row_addr_d = row_addr_q;

        // Software writes; an operation finishing in the same cycle wins.
        if (reg_wr_i) begin
            case (reg_addr_i)
                REG_PTR_UPPER: begin
                    ptr_d[PTR_W-1:16] =
                        reg_wdata_i[UPPER_IMPL_W-1:0];
                end
                REG_PTR_HIGH: begin
                    ptr_d[15:8] = reg_wdata_i;
                end
                REG_PTR_LOW: begin
                    ptr_d[7:0] = reg_wdata_i;
                end
                REG_LATCH: begin
                    latch_d = reg_wdata_i;
                end
                REG_BUS_CTRL: begin
                    wait_d = reg_wdata_i[WAIT_LSB +: WAIT_W];
                end
                default: begin
                    latch_d = latch_d;
                end
            endcase
        end

        case (state_q)
            ST_IDLE: begin
                if (accept) begin
                    // Any byte address is legal; no alignment is checked.
                    addr_d = access_ptr;
                    after_d = after_ptr;
                    ptr_d = access_ptr;
                    write_d = op_write_i;
                    // Waits apply to all ops.
                    cnt_d = {2'b00, ttu_wait_extra(wait_q)}
                            * CLK_PER_TCY[WAIT_W+1:0];
                    state_d = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 4'h1;
                end else begin
                    // One byte only; wider values take several operations.
                    if (!write_q) begin
                        latch_d = read_byte;
                    end
                    // The last byte of a block commits the whole block.
                    // Earlier bytes only fill the buffer.
                    if (blk_wr && (addr_q[BLK_OFS_W-1:0] == 6'h3F)) begin
                        row_prog_d = 1'b1;
                        row_addr_d = {addr_q[PTR_W-1:BLK_OFS_W],
                                      6'h00};
                    end
                    // Post steps land after the access.
                    ptr_d = after_q;
                    done_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Registers the sequencer and software-visible state.
    // Reset leaves the unit idle.
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= ST_IDLE;
            ptr_q <= PTR_RST;
            after_q <= PTR_RST;
            latch_q <= LATCH_RST;
            wait_q <= WAIT_RST;
            cnt_q <= '0;
            write_q <= 1'b0;
            addr_q <= PTR_RST;
            done_q <= 1'b0;
            row_prog_q <= 1'b0;
            row_addr_q <= PTR_RST;
        end else begin
            state_q <= state_d;
            ptr_q <= ptr_d;
            after_q <= after_d;
            latch_q <= latch_d;
            wait_q <= wait_d;
            cnt_q <= cnt_d;
            write_q <= write_d;
            addr_q <= addr_d;
            done_q <= done_d;
            row_prog_q <= row_prog_d;
            row_addr_q <= row_addr_d;
        end
    end

    // Read data for the software port, valid the cycle after the strobe.
    // Zero outside the answer cycle.
    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                REG_PTR_UPPER: begin
                    rdata_d = {2'b00, ptr_q[PTR_W-1:16]};
                end
                REG_PTR_HIGH: begin
                    rdata_d = ptr_q[15:8];
                end
                REG_PTR_LOW: begin
                    rdata_d = ptr_q[7:0];
                end
                REG_LATCH: begin
                    rdata_d = latch_q;
                end
                REG_BUS_CTRL: begin
                    rdata_d[WAIT_LSB +: WAIT_W] = wait_q;
                end
                // Busy, mode and space select bits.
                REG_STATUS: begin
                    rdata_d[STAT_BUSY_BIT] = (state_q != ST_IDLE);
                    rdata_d[STAT_PROG_BIT] = prog_sync_q;
                    rdata_d[STAT_CFG_BIT] = ptr_q[CFG_SEL_BIT];
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    // Holds the read answer for exactly one cycle.
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Memory side: address and data come from registers during an access.
    // The address stays until the next op; the data follows the latch, which reads and latch writes change.
    assign mem_addr_o = addr_q;
    assign mem_cfg_sel_o = addr_q[CFG_SEL_BIT];
    assign mem_rd_o = (state_q == ST_ACCESS) && !write_q;
    // External writes only outside programming mode.
    assign mem_wr_o = (state_q == ST_ACCESS) && write_q
                      && !prog_sync_q;
    assign mem_wdata_o = latch_q;
    assign op_done_o = done_q;
    assign reg_rdata_o = rdata_q;
    assign row_prog_o = row_prog_q;
    assign row_addr_o = row_addr_q;

endmodule

// *** src/ttu_pkg.sv ***
// Constants, types and helpers for the table transfer unit.
// Assumes a single core clock and an asynchronous active-high reset.
// Summary of operation
// - Each table read moves exactly one byte.
// - Table read loads addressed byte into latch.
// - Pointer bit 0 picks high or low byte.
// - Table write drives pointer and latch outward.
// - Normal mode never writes the internal array.
// - Data accepted at any byte address.
// - Programming mode writes 64-byte, 32-word blocks.
// - Blocks align with code protection blocks.
// - Upper register holds bits 21..16, top bits zero.
// - High and low registers hold bits 15..0.
// - Four pointer updates: hold, post-inc, post-dec, pre-inc.
// - Steps change low 21 bits; 22 bits address.
// - Pointer bit 21 selects configuration space.
// - Wait field 11..00 adds 0..3 instruction cycles.
package ttu_pkg;

    // Widths of the pointer, its counting part and the data paths.
    localparam int PTR_W = 22;
    localparam int CNT_W = 21;
    localparam int DATA_W = 8;
    localparam int WORD_W = 16;
    localparam int REG_AW = 3;

    // Programming block geometry.
    localparam int BLK_BYTES = 64;
    localparam int BLK_WORDS = 32;
    localparam int BLK_OFS_W = 6;

    // Register offsets on the software port.
    localparam logic [REG_AW-1:0] REG_PTR_UPPER = 3'h0;
    localparam logic [REG_AW-1:0] REG_PTR_HIGH = 3'h1;
    localparam logic [REG_AW-1:0] REG_PTR_LOW = 3'h2;
    localparam logic [REG_AW-1:0] REG_LATCH = 3'h3;
    localparam logic [REG_AW-1:0] REG_BUS_CTRL = 3'h4;
    localparam logic [REG_AW-1:0] REG_STATUS = 3'h5;

    // Field positions.
    localparam int UPPER_IMPL_W = 6;
    localparam int WAIT_LSB = 4;
    localparam int WAIT_W = 2;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_PROG_BIT = 1;
    localparam int STAT_CFG_BIT = 2;
    localparam int CFG_SEL_BIT = 21;

    // Reset values.
    localparam logic [PTR_W-1:0] PTR_RST = 22'h000000;
    localparam logic [DATA_W-1:0] LATCH_RST = 8'h00;
    localparam logic [WAIT_W-1:0] WAIT_RST = 2'h0;

    // Timing: the core clock period and the instruction cycle length.
    localparam int CLK_PERIOD_NS = 100;
    localparam int TCY_NS = 100;
    localparam int CLK_PER_TCY = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Pointer update chosen by each table operation.
    typedef enum logic [1:0] {
        PTR_HOLD = 2'h0,
        PTR_POST_INC = 2'h1,
        PTR_POST_DEC = 2'h2,
        PTR_PRE_INC = 2'h3
    } ttu_ptr_mode_type;

    // Extra instruction cycles for a wait field; 11 gives none, 00 three.
    function automatic logic [WAIT_W-1:0] ttu_wait_extra(
        input logic [WAIT_W-1:0] field
    );
        ttu_wait_extra = ~field;
    endfunction

    // Steps the low 21 bits of the pointer, keeping bit 21 as it is.
    function automatic logic [PTR_W-1:0] ttu_ptr_step(
        input logic [PTR_W-1:0] ptr,
        input logic down
    );
        logic [CNT_W-1:0] low;
        low = down ? ptr[CNT_W-1:0] - 21'h000001
                   : ptr[CNT_W-1:0] + 21'h000001;
        ttu_ptr_step = {ptr[PTR_W-1], low};
    endfunction

endpackage

// *** src/ttu_ptr_update.sv ***
// Pointer arithmetic for one table operation.
// Purely combinational; the caller registers both results.
module ttu_ptr_update (
    input wire logic [ttu_pkg::PTR_W-1:0] ptr_i,
    input wire ttu_pkg::ttu_ptr_mode_type mode_i,
    output logic [ttu_pkg::PTR_W-1:0] access_ptr_o,
    output logic [ttu_pkg::PTR_W-1:0] after_ptr_o
);
    import ttu_pkg::*;

    // Selects the address used by the access and the pointer left after it.
    always_comb begin
        access_ptr_o = ptr_i;
        after_ptr_o = ptr_i;
        case (mode_i)
            PTR_HOLD: begin
                after_ptr_o = ptr_i;
            end
            PTR_POST_INC: begin
                after_ptr_o = ttu_ptr_step(ptr_i, 1'b0);
            end
            PTR_POST_DEC: begin
                after_ptr_o = ttu_ptr_step(ptr_i, 1'b1);
            end
            PTR_PRE_INC: begin
                access_ptr_o = ttu_ptr_step(ptr_i, 1'b0);
                after_ptr_o = access_ptr_o;
            end
            default: begin
                after_ptr_o = ptr_i;
            end
        endcase
    end

endmodule

// *** src/ttu_blk_buf.sv ***
// Block write buffer that gathers bytes of one programming block.
// Assumes the owner decides when a full block is committed.
module ttu_blk_buf #(
    parameter int BYTES = ttu_pkg::BLK_BYTES,
    parameter int OFS_W = ttu_pkg::BLK_OFS_W
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic wr_i,
    input wire logic [OFS_W-1:0] ofs_i,
    input wire logic [ttu_pkg::DATA_W-1:0] byte_i,
    output logic [BYTES*ttu_pkg::DATA_W-1:0] row_o
);
    import ttu_pkg::*;

    logic [DATA_W-1:0] buf_q [BYTES];
    logic [DATA_W-1:0] buf_d [BYTES];

    // Stores a byte at its offset within the block.
    always_comb begin
        for (int i = 0; i < BYTES; i++) begin
            buf_d[i] = buf_q[i];
        end
        if (wr_i) begin
            buf_d[ofs_i] = byte_i;
        end
    end

    // Registers the block contents.
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < BYTES; i++) begin
                buf_q[i] <= LATCH_RST;
            end
        end else begin
            for (int i = 0; i < BYTES; i++) begin
                buf_q[i] <= buf_d[i];
            end
        end
    end

    // Packs the block with byte 0 in the lowest bits.
    always_comb begin
        for (int i = 0; i < BYTES; i++) begin
            row_o[i*DATA_W +: DATA_W] = buf_q[i];
        end
    end

endmodule

// *** verification/ttu_table_unit_monitor.sv ***
// Port checker for the table transfer unit.
// Assumes one core clock and the unit's asynchronous high reset.
module ttu_table_unit_monitor (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [ttu_pkg::REG_AW-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic op_valid_i,
    input wire logic op_ready_o,
    input wire logic op_done_o,
    input wire logic [ttu_pkg::PTR_W-1:0] mem_addr_o,
    input wire logic mem_cfg_sel_o,
    input wire logic mem_rd_o,
    input wire logic mem_wr_o,
    input wire logic [ttu_pkg::DATA_W-1:0] mem_wdata_o,
    input wire logic [ttu_pkg::WORD_W-1:0] mem_rdata_i,
    input wire logic prog_mode_i,
    input wire logic row_prog_o,
    input wire logic [ttu_pkg::PTR_W-1:0] row_addr_o
);
    import ttu_pkg::*;
    logic [DATA_W-1:0] pick;
    logic latch_wr;
    // Byte a read of this address must keep, and a software latch write.
    assign pick = mem_addr_o[0] ? mem_rdata_i[15:8] : mem_rdata_i[7:0];
    assign latch_wr = reg_wr_i && (reg_addr_i == REG_LATCH);
    // Every check runs on the core clock and pauses in reset.
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_cfg_select: assert property (mem_cfg_sel_o == mem_addr_o[21])
        else $error("space select differs from pointer top bit");
    a_op_latency: assert property (
        op_valid_i && op_ready_o |-> ##[2:5] op_done_o)
        else $error("table op did not finish in time");
    a_done_idle: assert property (
        op_done_o |-> !mem_rd_o && !mem_wr_o && op_ready_o)
        else $error("access still active at completion");
    a_read_pick: assert property (
        op_done_o && $past(mem_rd_o) |-> mem_wdata_o == $past(pick))
        else $error("latch holds the wrong byte of the word");
    a_latch_keep: assert property (
        $changed(mem_wdata_o) |-> op_done_o || $past(latch_wr))
        else $error("latch changed without a cause");
    a_write_stable: assert property (
        mem_wr_o && $past(mem_wr_o) |-> $stable(mem_addr_o)
        && $stable(mem_wdata_o))
        else $error("write address or data moved");
    a_no_prog_norm: assert property (
        !prog_mode_i [*6] |-> !row_prog_o)
        else $error("block commit outside programming mode");
    a_prog_no_wr: assert property (
        prog_mode_i [*8] |-> !mem_wr_o)
        else $error("external write in programming mode");
    a_block_base: assert property (
        row_prog_o |-> mem_addr_o[5:0] == 6'h3F
        && row_addr_o == {mem_addr_o[21:6], 6'h00})
        else $error("block commit misaligned");
    a_block_done: assert property (row_prog_o |-> op_done_o)
        else $error("block commit apart from op completion");

    c_read: cover property (op_done_o && $past(mem_rd_o));
    c_write: cover property (mem_wr_o);
    c_commit: cover property (row_prog_o);
endmodule

bind ttu_table_unit ttu_table_unit_monitor i_mon (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .op_valid_i(op_valid_i),
    .op_ready_o(op_ready_o), .op_done_o(op_done_o),
    .mem_addr_o(mem_addr_o), .mem_cfg_sel_o(mem_cfg_sel_o),
    .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(mem_rdata_i), .prog_mode_i(prog_mode_i),
    .row_prog_o(row_prog_o), .row_addr_o(row_addr_o)
);

// *** verification/ttu_mem_model.sv ***
// Behavioural program memory answering the table transfer unit.
// Assumes the unit holds the address through the whole access.
module ttu_mem_model (
    input wire logic core_clk_i,
    input wire logic [ttu_pkg::PTR_W-1:0] mem_addr_i,
    input wire logic mem_rd_i,
    output logic [ttu_pkg::WORD_W-1:0] mem_rdata_o
);
    import ttu_pkg::*;
    logic [WORD_W-1:0] last_q;
    logic [WORD_W-1:0] word;
    // Sixteen-bit word made from the word address and the space select.
    assign word = {mem_addr_i[8:1] ^ 8'h5A,
                   mem_addr_i[8:1] ^ {mem_addr_i[21], 7'h00}};
    // Outside an access the bus shows the inverse of the last word.
    assign mem_rdata_o = mem_rd_i ? word : ~last_q;
    // Remembers the word last driven.
    always_ff @(posedge core_clk_i) begin
        if (mem_rd_i) begin
            last_q <= word;
        end
    end
endmodule

// *** verification/ttu_table_unit_tb_top.sv ***
// Self-checking bench for the table transfer unit.
// Assumes the memory model answers within the access cycle.
module ttu_table_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ttu_pkg::*;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [REG_AW-1:0] reg_addr_i = 3'h0;
    logic [DATA_W-1:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic op_valid_i = 1'b0;
    logic op_write_i = 1'b0;
    ttu_ptr_mode_type op_mode_i = PTR_HOLD;
    logic prog_mode_i = 1'b0;
    logic [WORD_W-1:0] mem_rdata_i;
    logic [DATA_W-1:0] reg_rdata_o, mem_wdata_o, seen_wd, d;
    logic op_ready_o, op_done_o, mem_cfg_sel_o, mem_rd_o, mem_wr_o;
    logic row_prog_o, seen_wr, prog_wr;
    logic [PTR_W-1:0] mem_addr_o, row_addr_o, seen_addr, row_a, p;
    logic [BLK_BYTES*DATA_W-1:0] row_data_o, seen_row, exp_row;
    logic [PTR_W-1:0] after_tab [4] = '{22'h211, 22'h212, 22'h210, 22'h212};
    int n_fail = 0;
    int checks_done = 0;
    int k, got_row;

    // Core clock at 100 ns.
    always #50 core_clk_i = ~core_clk_i;

    ttu_table_unit i_dut (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .op_valid_i(op_valid_i), .op_write_i(op_write_i),
        .op_mode_i(op_mode_i), .op_ready_o(op_ready_o),
        .op_done_o(op_done_o), .mem_addr_o(mem_addr_o),
        .mem_cfg_sel_o(mem_cfg_sel_o), .mem_rd_o(mem_rd_o),
        .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
        .mem_rdata_i(mem_rdata_i), .prog_mode_i(prog_mode_i),
        .row_prog_o(row_prog_o), .row_addr_o(row_addr_o),
        .row_data_o(row_data_o)
    );
    ttu_mem_model i_mem (.core_clk_i(core_clk_i), .mem_addr_i(mem_addr_o),
        .mem_rd_i(mem_rd_o), .mem_rdata_o(mem_rdata_i));

    // Byte the memory model holds at a byte address.
    function automatic logic [7:0] mbyte(input logic [PTR_W-1:0] a);
        mbyte = a[0] ? a[8:1] ^ 8'h5A : a[8:1] ^ {a[21], 7'h00};
    endfunction

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wreg(input logic [2:0] a, input logic [7:0] v);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rreg(input logic [2:0] a, output logic [7:0] v);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        v = reg_rdata_o;
    endtask

    task automatic wptr(input logic [PTR_W-1:0] v);
        wreg(REG_PTR_UPPER, {2'b00, v[21:16]});
        wreg(REG_PTR_HIGH, v[15:8]);
        wreg(REG_PTR_LOW, v[7:0]);
    endtask

    task automatic rptr(output logic [PTR_W-1:0] v);
        logic [7:0] u, h, l;
        rreg(REG_PTR_UPPER, u);
        rreg(REG_PTR_HIGH, h);
        rreg(REG_PTR_LOW, l);
        v = {u[5:0], h, l};
    endtask

    // One table op; k counts edges from take to completion.
    task automatic op(input logic w, input ttu_ptr_mode_type m,
                      output int k);
        @(posedge core_clk_i);
        op_valid_i <= 1'b1;
        op_write_i <= w;
        op_mode_i <= m;
        @(posedge core_clk_i);
        op_valid_i <= 1'b0;
        k = 0;
        seen_wr = 1'b0;
        #1;
        while (k < 8 && op_done_o !== 1'b1) begin
            if (mem_rd_o === 1'b1 || mem_wr_o === 1'b1) begin
                seen_addr = mem_addr_o;
                seen_wd = mem_wdata_o;
            end
            seen_wr |= mem_wr_o;
            @(posedge core_clk_i);
            #1;
            k++;
        end
        if (row_prog_o === 1'b1) begin
            got_row++;
            row_a = row_addr_o;
            seen_row = row_data_o;
        end
        if (k >= 8) begin
            n_fail++;
            report_and_stop();
        end
    endtask

    // Hang guard.
    initial begin
        repeat (20000) @(posedge core_clk_i);
        n_fail++;
        report_and_stop();
    end

    // Main sequence.
    initial begin
        repeat (6) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            rreg(a[2:0], d);
            chk("reset value", 0, d);
        end
        wreg(REG_PTR_UPPER, 8'hFF);
        rreg(REG_PTR_UPPER, d);
        chk("upper reg", 8'h3F, d);
        wreg(REG_PTR_HIGH, 8'hA5);
        rreg(REG_PTR_HIGH, d);
        chk("high reg", 8'hA5, d);
        wreg(3'h6, 8'hFF);
        rreg(3'h6, d);
        chk("unmapped", 0, d);
        for (int w = 0; w < 4; w++) begin
            wreg(REG_BUS_CTRL, {2'b00, w[1:0], 4'h0});
            rreg(REG_BUS_CTRL, d);
            chk("wait field", {w[1:0], 4'h0}, d);
            wptr(22'h000100);
            op(1'b0, PTR_HOLD, k);
            chk("wait edges", 4 - w, k);
            rreg(REG_LATCH, d);
            chk("latch", mbyte(22'h000100), d);
        end
        for (int m = 0; m < 4; m++) begin
            wptr(22'h000211);
            op(1'b0, ttu_ptr_mode_type'(m[1:0]), k);
            p = (m == 3) ? 22'h000212 : 22'h000211;
            chk("access addr", p, seen_addr);
            rreg(REG_LATCH, d);
            chk("latch", mbyte(p), d);
            rptr(p);
            chk("ptr after", after_tab[m], p);
        end
        wptr(22'h3FFFFF);
        op(1'b0, PTR_POST_INC, k);
        chk("cfg select", 1, mem_cfg_sel_o);
        rreg(REG_LATCH, d);
        chk("cfg latch", mbyte(22'h3FFFFF), d);
        rptr(p);
        chk("wrap up", 22'h200000, p);
        op(1'b0, PTR_POST_DEC, k);
        rptr(p);
        chk("wrap down", 22'h3FFFFF, p);
        got_row = 0;
        wreg(REG_LATCH, 8'hC3);
        wptr(22'h001235);
        op(1'b1, PTR_POST_INC, k);
        chk("wr addr", 22'h001235, seen_addr);
        chk("wr data", 8'hC3, seen_wd);
        chk("wr strobe", 1, seen_wr);
        chk("commit", 0, got_row);
        rreg(REG_LATCH, d);
        chk("latch kept", 8'hC3, d);
        // A reset cuts the next write short; it is checked and redone.
        @(posedge core_clk_i);
        op_valid_i <= 1'b1;
        @(posedge core_clk_i);
        op_valid_i <= 1'b0;
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        rptr(p);
        chk("ptr reset", 0, p);
        wreg(REG_LATCH, 8'hC3);
        wptr(22'h001236);
        op(1'b1, PTR_HOLD, k);
        chk("redo addr", 22'h001236, seen_addr);
        chk("redo data", 8'hC3, seen_wd);
        prog_mode_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        rreg(REG_STATUS, d);
        chk("status", 8'h02, d);
        wptr(22'h000040);
        prog_wr = 1'b0;
        for (int i = 0; i < 64; i++) begin
            wreg(REG_LATCH, i[7:0] ^ 8'h3C);
            exp_row[8*i +: 8] = i[7:0] ^ 8'h3C;
            op(1'b1, PTR_POST_INC, k);
            prog_wr |= seen_wr;
        end
        chk("commits", 1, got_row);
        chk("block base", 22'h000040, row_a);
        chk("ext strobe", 0, prog_wr);
        checks_done++;
        if (seen_row !== exp_row) begin
            n_fail++;
            $display("[ERR] block expected %h seen %h", exp_row, seen_row);
        end
        rptr(p);
        chk("ptr end", 22'h000080, p);
        report_and_stop();
    end
endmodule
